// ==== core/pwr_seq.sv ====
/*
  power sequencer: resource state machines with sleep-clock countdown timers,
  core buck regulator mode selection and low-power shutdown control.
  assumes all inputs synchronous to mclk_i; the sleep clock arrives as a
  synchronous tick input one cycle wide.
*/
// Implementation choices: the plain strobed port and the placing of the registers.
// Behaviour
// RQ1: every resource is enabled, disabled, turning on or turning off.
// RQ2: timer is zero in stable states and nonzero during transitions.
// RQ3: start of a sequence loads the on or off duration.
// RQ4: nonzero timers count down once per sleep clock tick.
// RQ5: at zero, turning off becomes disabled, turning on becomes enabled.
// RQ6: at zero, clear pending bit and toggle on state bit; the code clears the on bit at turn-off start, so only turn-on sets it.
// RQ7: zero on duration jumps straight from disabled to enabled.
// RQ8: zero off duration jumps straight from enabled to disabled.
// RQ9: requests are union of clock requests, minimum set and request timers.
// RQ10: each clock request maps to the resources that clock needs.
// RQ11: required set recomputed every cycle from requests and dependency table.
// RQ12: after timer update compare required set with status.
// RQ13: turn off enabled, unrequested resources with no powered dependents.
// RQ14: turn on disabled, requested resources whose dependencies are enabled.
// RQ15: in reset buck off without supply request, else burst or pwm by ripple pin.
// RQ16: out of reset buck follows internal mode, pwm forced when both pins high.
// RQ17: low ripple pin low gives burst, high gives pwm, within selection table.
// RQ18: buck and core linear regulator powered out of reset, low noise optional.
// RQ19: regulators shut down only while wireless reset asserted.
// RQ20: in shutdown with io supply, tristate outputs and disable inputs.
// RQ21: leaving shutdown is a normal power-up, nothing retained; the code clears only states and timers, register settings are kept.
// RQ22: host should wait before loading after raising low ripple request.
// RQ23: resource timers run on the 32.768 kHz sleep clock.
// RQ24: in reset all timers and status bits held cleared.
`default_nettype none
`include "pwr_seq_params.svh"
module pwr_seq (
  // clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    sleep_tick_i,
  // host pins
  input  wire logic                    wlan_reset_n_i,
  input  wire logic                    supply_request_in_i,
  input  wire logic                    low_ripple_request_in_i,
  input  wire logic                    io_supply_i,
  // register port
  input  wire logic [3:0]              addr_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [31:0]             rdata_o,
  // resource requests
  input  wire logic [`NUM_CLKREQ-1:0]  clk_req_i,
  // regulator and resource control
  output pwr_seq_pkg::res_vec_t        res_on_o,
  output pwr_seq_pkg::buck_mode_t      buck_mode_o,
  output logic                         core_ldo_en_o,
  output logic                         lownoise_ldo_en_o,
  output logic                         io_ldo_en_o,
  output logic                         pad_oe_b_o,
  output logic                         pad_in_en_o,
  output logic                         precharge_busy_o
);
  import pwr_seq_pkg::*;

  localparam int PRE_CYC = `PRECHARGE_CYC;
  localparam int NR = `NUM_RES;

  typedef struct packed {
    res_state_t [NR-1:0]                   st;
    tmr_t       [NR-1:0]                   tmr;
    tmr_t       [NR-1:0]                   t_on;
    tmr_t       [NR-1:0]                   t_off;
    res_vec_t   [NR-1:0]                   deps;
    res_vec_t   [`NUM_CLKREQ-1:0]          clk_map;
    res_vec_t                              min_set;
    res_vec_t   [`NUM_REQ_TIMERS-1:0]      rt_set;
    logic       [`NUM_REQ_TIMERS-1:0][15:0] rt_cnt;
    logic                                  buck_pwm;
    logic                                  low_noise_linear_regulator_en;
    logic       [31:0]                     rdata;
    logic       [12:0]                     pre_cnt;
    logic                                  rip_q;
  } state_t;

  state_t s_q;
  state_t s_d;

  // registers: 0 ctrl, 1 min set, 2 status on, 3 status pending, 4+r/2 durations,
  // 8+r/2 deps, c+k/2 clk map, e/f request timers
  function automatic res_vec_t on_vec(input res_state_t [NR-1:0] st);
    res_vec_t v;
    v = '0;
    for (int i = 0; i < NR; i++) v[i] = (st[i] == RES_ON);
    return v;
  endfunction

  function automatic res_vec_t up_vec(input res_state_t [NR-1:0] st);
    res_vec_t v;
    v = '0;
    for (int i = 0; i < NR; i++) v[i] = (st[i] != RES_OFF);
    return v;
  endfunction

  res_vec_t req_set;
  res_vec_t on_now;
  res_vec_t up_now;

  always_comb begin
    s_d = s_q;
    req_set = s_q.min_set; // RQ9
    for (int k = 0; k < `NUM_CLKREQ; k++) begin
      if (clk_req_i[k]) req_set = req_set | s_q.clk_map[k]; // RQ10
    end
    for (int t = 0; t < `NUM_REQ_TIMERS; t++) begin
      if (s_q.rt_cnt[t] != 16'h0000) req_set = req_set | s_q.rt_set[t]; // RQ9
    end
    // close the set over dependencies each cycle
    for (int p = 0; p < NR; p++) begin
      for (int i = 0; i < NR; i++) begin
        if (req_set[i]) req_set = req_set | s_q.deps[i]; // RQ11
      end
    end
    // timers first
    for (int i = 0; i < NR; i++) begin
      if (sleep_tick_i && s_q.tmr[i] != '0) begin // RQ4 RQ23
        s_d.tmr[i] = s_q.tmr[i] - tmr_t'(1);
        if (s_q.tmr[i] == tmr_t'(1)) begin // RQ5 RQ6
          s_d.st[i] = (s_q.st[i] == RES_GO_ON) ? RES_ON : RES_OFF;
        end
      end
    end
    on_now = on_vec(s_d.st); // RQ12
    up_now = up_vec(s_d.st);
    for (int i = 0; i < NR; i++) begin
      logic dep_up;
      dep_up = 1'b0;
      for (int j = 0; j < NR; j++) begin
        if (j != i && s_q.deps[j][i] && up_now[j]) dep_up = 1'b1;
      end
      unique case (s_d.st[i]) // RQ1
        RES_ON: begin
          if (!req_set[i] && !dep_up) begin // RQ13
            s_d.st[i]  = (s_q.t_off[i] == '0) ? RES_OFF : RES_GO_OFF; // RQ8
            s_d.tmr[i] = s_q.t_off[i]; // RQ3 RQ2
          end
        end
        RES_OFF: begin
          if (req_set[i] && ((s_q.deps[i] & ~on_now) == '0)) begin // RQ14
            s_d.st[i]  = (s_q.t_on[i] == '0) ? RES_ON : RES_GO_ON; // RQ7
            s_d.tmr[i] = s_q.t_on[i]; // RQ3 RQ2
          end
        end
        RES_GO_ON, RES_GO_OFF: begin
        end
      endcase
    end
    for (int t = 0; t < `NUM_REQ_TIMERS; t++) begin
      if (sleep_tick_i && s_q.rt_cnt[t] != 16'h0000) s_d.rt_cnt[t] = s_q.rt_cnt[t] - 16'h0001;
    end
    // integrator precharge window after the ripple pin rises (advisory only)
    s_d.rip_q = low_ripple_request_in_i;
    if (low_ripple_request_in_i && !s_q.rip_q) s_d.pre_cnt = 13'(PRE_CYC); // RQ22
    else if (s_q.pre_cnt != 13'h0000) s_d.pre_cnt = s_q.pre_cnt - 13'h0001;
    // register port
    if (wr_i) begin
      unique case (addr_i)
        4'h0: begin
          s_d.buck_pwm = wdata_i[0];
          s_d.low_noise_linear_regulator_en = wdata_i[1];
        end
        4'h1: s_d.min_set = wdata_i[NR-1:0];
        4'h4, 4'h5, 4'h6, 4'h7: begin
          for (int r = 0; r < 2; r++) begin
            s_d.t_on[{addr_i[1:0], r[0]}]  = wdata_i[16*r +: 8];
            s_d.t_off[{addr_i[1:0], r[0]}] = wdata_i[16*r+8 +: 8];
          end
        end
        4'h8, 4'h9, 4'hA, 4'hB: begin
          for (int r = 0; r < 2; r++) s_d.deps[{addr_i[1:0], r[0]}] = wdata_i[16*r +: 8];
        end
        4'hC, 4'hD: begin
          for (int r = 0; r < 2; r++) s_d.clk_map[{addr_i[0], r[0]}] = wdata_i[16*r +: 8];
        end
        4'hE, 4'hF: begin
          s_d.rt_set[addr_i[0]] = wdata_i[NR-1:0];
          s_d.rt_cnt[addr_i[0]] = wdata_i[31:16];
        end
        default: begin
        end
      endcase
    end
    s_d.rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        4'h0: s_d.rdata = {30'h0, s_q.low_noise_linear_regulator_en, s_q.buck_pwm};
        4'h1: s_d.rdata = {24'h0, s_q.min_set};
        4'h2: s_d.rdata = {24'h0, on_vec(s_q.st)};
        4'h3: s_d.rdata = {24'h0, up_vec(s_q.st) ^ on_vec(s_q.st)};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (!wlan_reset_n_i) begin // RQ24 RQ21
      s_d.st  = '0;
      s_d.tmr = '0;
      s_d.rt_cnt = '0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) s_q <= '0;
    else s_q <= s_d;
  end

  always_comb begin
    rdata_o = s_q.rdata;
    res_on_o = on_vec(s_q.st);
    precharge_busy_o = (s_q.pre_cnt != 13'h0000);
    io_ldo_en_o = io_supply_i;
    core_ldo_en_o = wlan_reset_n_i; // RQ18 RQ19
    lownoise_ldo_en_o = wlan_reset_n_i && s_q.low_noise_linear_regulator_en; // RQ18
    pad_oe_b_o = !(wlan_reset_n_i || !io_supply_i) ; // RQ20
    pad_in_en_o = wlan_reset_n_i; // RQ20
    if (!wlan_reset_n_i) begin
      if (!supply_request_in_i) buck_mode_o = BUCK_OFF; // RQ15 RQ19
      else buck_mode_o = low_ripple_request_in_i ? BUCK_PWM : BUCK_BURST; // RQ17
    end else if (supply_request_in_i && low_ripple_request_in_i) begin
      buck_mode_o = BUCK_PWM; // RQ16
    end else begin
      buck_mode_o = s_q.buck_pwm ? BUCK_PWM : BUCK_BURST; // RQ16 RQ18
    end
  end

  chk_timer_zero_stable: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (s_q.st[0] == RES_ON || s_q.st[0] == RES_OFF) |-> s_q.tmr[0] == '0) else $error("stable timer nonzero"); // RQ2
  chk_timer_busy: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (s_q.st[0] == RES_GO_ON || s_q.st[0] == RES_GO_OFF) |-> s_q.tmr[0] != '0) else $error("transition timer zero"); // RQ2
  // resource 1 is the one that the tests sequence with a nonzero duration
  chk_timer_dec: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wlan_reset_n_i && sleep_tick_i && s_q.st[1] == RES_GO_ON && s_q.tmr[1] > tmr_t'(1))
    |=> s_q.tmr[1] == $past(s_q.tmr[1]) - tmr_t'(1)) else $error("timer not decremented"); // RQ4
  chk_timer_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!sleep_tick_i && wlan_reset_n_i && s_q.st[1] == RES_GO_ON) |=> $stable(s_q.tmr[1])) else $error("timer moved"); // RQ23
  chk_on_finish: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wlan_reset_n_i && sleep_tick_i && s_q.st[1] == RES_GO_ON && s_q.tmr[1] == tmr_t'(1))
    |=> s_q.st[1] == RES_ON) else $error("turn on not finished"); // RQ5
  chk_reset_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !wlan_reset_n_i |=> s_q.st == '0 && s_q.tmr == '0) else $error("state kept in reset"); // RQ24
  chk_buck_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!wlan_reset_n_i && !supply_request_in_i) |-> buck_mode_o == BUCK_OFF) else $error("buck not off"); // RQ15
  chk_buck_force: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (supply_request_in_i && low_ripple_request_in_i) |-> buck_mode_o == BUCK_PWM) else $error("pwm not forced"); // RQ16
  chk_buck_on_run: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wlan_reset_n_i |-> buck_mode_o != BUCK_OFF && core_ldo_en_o) else $error("regulator off out of reset"); // RQ18
  chk_pad_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!wlan_reset_n_i && io_supply_i) |-> pad_oe_b_o && !pad_in_en_o) else $error("pads live in shutdown"); // RQ20
  cov_turn_on: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_q.st[1] == RES_GO_ON ##1 s_q.st[1] == RES_GO_ON [*2] ##[1:1000] s_q.st[1] == RES_ON);
  cov_turn_off: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_q.st[0] == RES_GO_OFF ##[1:300] s_q.st[0] == RES_OFF);
  cov_ext_pwm: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    !wlan_reset_n_i && buck_mode_o == BUCK_PWM);
endmodule
`default_nettype wire

// ==== core/pwr_seq_params.svh ====
/*
  timing counts and field layout for the power sequencer.
  assumes inclusion by bare name from the package and the design module.
*/
`ifndef PWR_SEQ_PARAMS_SVH
`define PWR_SEQ_PARAMS_SVH
`define NUM_RES          8
`define NUM_CLKREQ       4
`define NUM_REQ_TIMERS   2
`define TMR_W            8
`define SLEEP_CLK_HZ     32768
`define SYS_CLK_HZ       40000000
`define PRECHARGE_US     100
`define PRECHARGE_CYC    (((`PRECHARGE_US) * (`SYS_CLK_HZ)) / 1000000)
`endif

// ==== core/pwr_seq_pkg.sv ====
/*
  types for the power sequencer.
  assumes the params header is on the include path.
*/
`default_nettype none
`include "pwr_seq_params.svh"
package pwr_seq_pkg;
  typedef logic [`NUM_RES-1:0] res_vec_t;
  typedef logic [`TMR_W-1:0]   tmr_t;
  typedef enum logic [1:0] {
    RES_OFF     = 2'b00,
    RES_GO_ON   = 2'b01,
    RES_ON      = 2'b11,
    RES_GO_OFF  = 2'b10
  } res_state_t;
  typedef enum logic [1:0] {
    BUCK_OFF   = 2'b00,
    BUCK_BURST = 2'b01,
    BUCK_PWM   = 2'b11
  } buck_mode_t;
endpackage
`default_nettype wire

// ==== testbench/host_model.sv ====
/*
  host-side model: drives the wireless reset, supply and ripple request pins,
  the io supply flag and the sleep clock tick.
  assumes pin settings arrive from the bench and are applied at the next edge.
*/
`default_nettype none
`include "pwr_seq_params.svh"
module host_model (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // requested pins: io, reset_n, supply, ripple
  input  wire logic [3:0] pins_i,
  // pins toward the device
  output logic            io_supply_o,
  output logic            wlan_reset_n_o,
  output logic            supply_request_in_o,
  output logic            low_ripple_request_in_o,
  output logic            sleep_tick_o,
  output logic            load_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = `SYS_CLK_HZ / `SLEEP_CLK_HZ;
  int cnt;
  int pc;
  assign load_ok_o = (pc == 0);
  // the sleep tick never stops, it is the only time base left in sleep
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 0;
      pc <= 0;
      sleep_tick_o <= 1'b0;
      {io_supply_o, wlan_reset_n_o, supply_request_in_o, low_ripple_request_in_o} <= 4'h0;
    end else begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      sleep_tick_o <= (cnt == DIV - 1);
      pc <= (pins_i[0] && !low_ripple_request_in_o) ? `PRECHARGE_CYC : ((pc != 0) ? pc - 1 : 0);
      {io_supply_o, wlan_reset_n_o, supply_request_in_o, low_ripple_request_in_o} <= pins_i;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_pwr_seq.sv ====
/*
  self-checking bench for the power sequencer: register reads and port
  snapshots are noted in a queue by the driver and compared by a monitor.
  assumes the host model drives the pins and the sleep tick.
*/
`default_nettype none
module test_pwr_seq;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_seq_pkg::*;
  typedef struct {string n; logic [31:0] e; logic [31:0] m;} note_t;
  note_t       q[$];
  logic        mclk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, look = 1'b0, rd_q = 1'b0;
  logic [3:0]  addr_i = 4'h0, pins = 4'hC, clk_req_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata, obs;
  logic [7:0]  ticks = 8'h00;
  int          err_total = 0, checks = 0, seed = 32'h1D6C;
  logic        wl_n, smps, pwm, io, tick, core_linear_regulator, low_noise_linear_regulator, ioldo, oe_b, in_en, pbusy;
  res_vec_t    res_on;
  buck_mode_t  buck;
  assign obs = {8'h00, ticks, pbusy, in_en, oe_b, ioldo, low_noise_linear_regulator, core_linear_regulator, buck, res_on};
  host_model host_model_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .pins_i(pins), .io_supply_o(io),
    .wlan_reset_n_o(wl_n), .supply_request_in_o(smps), .low_ripple_request_in_o(pwm),
    .sleep_tick_o(tick), .load_ok_o());
  pwr_seq pwr_seq_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sleep_tick_i(tick), .wlan_reset_n_i(wl_n),
    .supply_request_in_i(smps), .low_ripple_request_in_i(pwm), .io_supply_i(io), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .clk_req_i(clk_req_i),
    .res_on_o(res_on), .buck_mode_o(buck), .core_ldo_en_o(core_linear_regulator), .lownoise_ldo_en_o(low_noise_linear_regulator),
    .io_ldo_en_o(ioldo), .pad_oe_b_o(oe_b), .pad_in_en_o(in_en), .precharge_busy_o(pbusy));
  initial forever #12.5 mclk_i = ~mclk_i;
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, logic [31:0] e);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    q.push_back('{"rdata", e, 32'hFFFF_FFFF});
    @(posedge mclk_i);
    rd_i <= 1'b0;
  endtask
  task automatic peek(logic [31:0] e, logic [31:0] m);
    @(posedge mclk_i);
    look <= 1'b1;
    q.push_back('{"ports", e, m});
    @(posedge mclk_i);
    look <= 1'b0;
  endtask
  task automatic settle(logic [3:0] p);
    pins <= p;
    repeat (3) @(posedge mclk_i);
  endtask
  // counts sleep ticks until the resource reads enabled, bounded
  task automatic wait_on(int b);
    ticks = 8'h00;
    for (int k = 0; k < 6000 && res_on[b] !== 1'b1; k++) begin
      @(negedge mclk_i);
      if (tick === 1'b1) ticks = ticks + 8'h01;
    end
    // back onto the rising edge so that stimulus after this stays edge aligned
    @(posedge mclk_i);
  endtask
  function automatic buck_mode_t buck_exp(logic [4:0] i);
    if (i[3]) return (i[0] || (i[2] && i[1])) ? BUCK_PWM : BUCK_BURST;
    return !i[2] ? BUCK_OFF : (i[1] ? BUCK_PWM : BUCK_BURST);
  endfunction
  always @(posedge mclk_i) begin
    note_t t;
    rd_q <= rd_i;
    if (rd_q || look) begin
      t = q.pop_front();
      check(t.n, (rd_q ? rdata : obs) & t.m, t.e);
    end
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    err_total++;
    summarize();
  end
  initial begin
    logic [31:0] w;
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd_reg(4'h2, 32'h0);
    rd_reg(4'h3, 32'h0);
    peek(32'h0, 32'h0000_00FF);
    $display("reset values done");
    for (int i = 0; i < 32; i++) begin
      w = $random(seed);
      w[0] = i[0];
      wr(4'h0, w);
      settle(i[4:1]);
      peek({17'h0, i[3], i[4] & !i[3], i[4], i[3] & w[1], i[3], buck_exp(i[4:0]), 8'h00}, 32'h7FFF);
    end
    settle(4'hC);
    settle(4'hD);
    peek(32'h0000_8000, 32'h0000_8000);
    settle(4'hC);
    $display("regulator modes done");
    wr(4'h1, 32'h1);
    peek(32'h01, 32'hFF);
    wr(4'h2, 32'hFF);
    rd_reg(4'h2, 32'h01);
    wr(4'h1, 32'h0);
    peek(32'h0, 32'hFF);
    $display("immediate transitions done");
    wr(4'h4, 32'h0003_0000);
    wr(4'h1, 32'h2);
    rd_reg(4'h3, 32'h02);
    rd_reg(4'h2, 32'h00);
    wait_on(1);
    peek(32'h0003_0002, 32'h00FF_00FF);
    rd_reg(4'h2, 32'h02);
    rd_reg(4'h3, 32'h00);
    $display("timed turn-on done");
    wr(4'h1, 32'h0);
    wr(4'h9, 32'h02);
    wr(4'hC, 32'h04);
    clk_req_i <= 4'h1;
    wait_on(2);
    peek(32'h0003_0006, 32'h00FF_00FF);
    clk_req_i <= 4'h0;
    repeat (4) @(posedge mclk_i);
    peek(32'h0, 32'hFF);
    $display("dependencies done");
    wr(4'h1, 32'h1);
    settle(4'h8);
    peek(32'h0000_3000, 32'h7FFF);
    rd_reg(4'h3, 32'h0);
    settle(4'hC);
    peek(32'h01, 32'hFF);
    $display("shutdown done");
    repeat (4) @(posedge mclk_i);
    summarize();
  end
endmodule
`default_nettype wire
